//--- hw/uds_map.svh
`ifndef UDS_MAP_SVH
`define UDS_MAP_SVH

// Register byte offsets
`define UDS_CTRL_OFS     12'h000
`define UDS_STAT_OFS     12'h004
`define UDS_TOGL_OFS     12'h008

// Control register fields and reset value
`define UDS_CTRL_RWK_BIT 0
`define UDS_CTRL_HS_BIT  1
`define UDS_CTRL_RST     2'h0

// Status register fields
`define UDS_STAT_ST_LSB  0
`define UDS_STAT_SUS_BIT 3
`define UDS_STAT_SLF_BIT 4
`define UDS_STAT_HS_BIT  5
`define UDS_STAT_RWK_BIT 6
`define UDS_STAT_ADR_LSB 8
`define UDS_STAT_CFG_LSB 16

// Reset values of device state
`define UDS_DEF_ADDR     7'h00
`define UDS_CFG_NONE     8'h00

// Bus idle time before suspend
`define UDS_IDLE_MS      3
`define UDS_CLK_KHZ      200000
`define UDS_IDLE_CYC     (`UDS_IDLE_MS * `UDS_CLK_KHZ)
`define UDS_IDLE_W       20

`define UDS_EP_NUM       16

`endif

//--- hw/uds_pkg.sv
package uds_pkg;

  typedef enum logic [2:0] {
    UDS_ST_UNATT,
    UDS_ST_ATTACHED,
    UDS_ST_POWERED,
    UDS_ST_DEFAULT,
    UDS_ST_ADDRESS,
    UDS_ST_CONFIGURED,
    UDS_ST_SUSPENDED
  } uds_state_t;

  typedef enum logic [1:0] {
    UDS_REG_CTRL,
    UDS_REG_STAT,
    UDS_REG_TOGL,
    UDS_REG_NONE
  } uds_reg_t;

endpackage : uds_pkg

//--- hw/uds_idle_timer.sv
`timescale 1ns/1ps
`include "uds_map.svh"

module uds_idle_timer
  import uds_pkg::*;
#(
  parameter int unsigned CYCLES = `UDS_IDLE_CYC
) (
  input  wire logic clk_in,      // Device clock
  input  wire logic rst_b_in,    // Async reset, active low
  input  wire logic activity_in, // Bus activity seen this cycle
  output logic      idle_out     // Bus quiet for the full idle time
);

  localparam logic [`UDS_IDLE_W-1:0] LIMIT =
    `UDS_IDLE_W'((CYCLES > 1) ? CYCLES - 1 : 0);

  logic [`UDS_IDLE_W-1:0] cnt_q;

  // Saturates so a long quiet bus cannot wrap back to busy
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q    <= '0;
      idle_out <= 1'b0;
    end else if (activity_in) begin
      cnt_q    <= '0;
      idle_out <= 1'b0;
    end else if (cnt_q == LIMIT) begin
      idle_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule : uds_idle_timer

//--- hw/uds_ep_toggle.sv
`timescale 1ns/1ps
`include "uds_map.svh"

module uds_ep_toggle
  import uds_pkg::*;
(
  input  wire logic                   clk_in,      // Device clock
  input  wire logic                   rst_b_in,    // Async reset, active low
  input  wire logic                   clr_all_in,  // All toggles to DATA0
  input  wire logic [`UDS_EP_NUM-1:0] clr_mask_in, // Per endpoint to DATA0
  input  wire logic [`UDS_EP_NUM-1:0] flip_in,     // Per endpoint advance
  output logic      [`UDS_EP_NUM-1:0] toggle_out   // 0 = DATA0, 1 = DATA1
);

  for (genvar i = 0; i < `UDS_EP_NUM; i++) begin : g_ep
    // Clearing wins: a data phase racing a reconfigure is void
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        toggle_out[i] <= 1'b0;
      end else if (clr_all_in || clr_mask_in[i]) begin
        toggle_out[i] <= 1'b0;
      end else if (flip_in[i]) begin
        toggle_out[i] <= ~toggle_out[i];
      end
    end
  end

endmodule : uds_ep_toggle

//--- hw/uds_state_tracker.sv
// Notes on behaviour
// - Before the first complete bus reset, ignore all traffic and send nothing.
// - Completing a bus reset enters Default, answering the default address.
// - Bus reset clears address, configuration, toggles and other device state.
// - Endpoint zero is answered at default and at assigned address.
// - Nonzero address assignment moves Default to Address; answer there after.
// - Configured only after a successful nonzero set-configuration request.
// - Configure or alternate change returns affected endpoint toggles to DATA0.
// - Suspended keeps address, configuration and other status.
// - Disabled upstream port suspends the device. The code does so only from Default, Address or Configured, not from Powered.
// - Bus activity ends suspend.
// - Remote wakeup enable is host controlled, cleared by every bus reset.
// - Powered only once attached and bus supply is present.
// - Present power source is reported in status, tracking every change.
// - Source change under single-mode configuration drops to Powered.
// - High power configuration switching to bus power falls back to Address.
// - Speed is decided at reset; full speed operation stays correct.
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "uds_map.svh"

module uds_state_tracker
  import uds_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `UDS_IDLE_CYC
) (
  input  wire logic                   clk_in,             // 200 MHz clock
  input  wire logic                   rst_b_in,           // Async, active low
  input  wire logic                   hsel_in,            // AHB select
  input  wire logic [11:0]            haddr_in,           // AHB address
  input  wire logic [1:0]             htrans_in,          // AHB transfer
  input  wire logic                   hwrite_in,          // AHB write
  input  wire logic [2:0]             hsize_in,           // AHB size
  input  wire logic [31:0]            hwdata_in,          // AHB write data
  input  wire logic                   hready_in,          // AHB ready
  output logic      [31:0]            hrdata_out,         // AHB read data
  output logic                        hreadyout_out,      // AHB ready out
  output logic                        hresp_out,          // AHB response
  input  wire logic                   attached_in,        // Cable attached
  input  wire logic                   vbus_in,            // Bus supply
  input  wire logic                   self_powered_in,    // Local supply used
  input  wire logic                   bus_reset_in,       // Reset signalling
  input  wire logic                   bus_activity_in,    // Bus traffic seen
  input  wire logic                   port_enabled_in,    // Hub port enabled
  input  wire logic                   hs_chirp_ok_in,     // HS handshake ok
  input  wire logic                   tok_valid_in,       // Token received
  input  wire logic [6:0]             tok_addr_in,        // Token address
  input  wire logic [3:0]             tok_ep_in,          // Token endpoint
  input  wire logic                   set_addr_in,        // Address req done
  input  wire logic [6:0]             addr_val_in,        // Address value
  input  wire logic                   set_cfg_in,         // Config req done
  input  wire logic [7:0]             cfg_val_in,         // Config value
  input  wire logic                   set_alt_in,         // Alt setting done
  input  wire logic [`UDS_EP_NUM-1:0] alt_ep_mask_in,     // Its endpoints
  input  wire logic                   cfg_single_mode_in, // Cfg one source
  input  wire logic                   cfg_high_power_in,  // Cfg over 100 mA
  input  wire logic                   rwake_set_in,       // Enable wakeup
  input  wire logic                   rwake_clr_in,       // Disable wakeup
  input  wire logic [`UDS_EP_NUM-1:0] ep_flip_in,         // Toggle advance
  output uds_state_t                  state_out,          // Visible state
  output logic      [6:0]             dev_addr_out,       // Device address
  output logic      [7:0]             cfg_val_out,        // Configuration
  output logic                        suspended_out,      // In suspend
  output logic                        rwake_en_out,       // Wakeup enabled
  output logic                        self_pwr_out,       // Power source
  output logic                        high_speed_out,     // HS operation
  output logic                        accept_out,         // Token accepted
  output logic      [`UDS_EP_NUM-1:0] ep_toggle_out       // Toggle bits
);

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic is_live(input uds_state_t st);
    return (st == UDS_ST_DEFAULT) || (st == UDS_ST_ADDRESS) ||
           (st == UDS_ST_CONFIGURED);
  endfunction : is_live

  function automatic uds_reg_t reg_sel(input logic [11:0] a);
    if (a == `UDS_CTRL_OFS) begin
      return UDS_REG_CTRL;
    end else if (a == `UDS_STAT_OFS) begin
      return UDS_REG_STAT;
    end else if (a == `UDS_TOGL_OFS) begin
      return UDS_REG_TOGL;
    end else begin
      return UDS_REG_NONE;
    end
  endfunction : reg_sel

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  uds_state_t  state_q;
  uds_state_t  resume_q;
  logic [6:0]  dev_addr_q;
  logic [7:0]  cfg_q;
  logic        bus_rst_q;
  logic        self_pwr_q;
  logic        hs_q;
  logic        rwake_q;
  logic        accept_q;
  logic [1:0]  ctrl_q;
  logic        wr_pend_q;
  uds_reg_t    wr_sel_q;
  logic [31:0] hrdata_q;
  logic [31:0] status_w;
  logic        idle_w;
  logic        reset_done;
  logic        pwr_chg;
  logic        go_susp;
  logic        pwr_drop;
  logic        pwr_fall;
  logic        base_ok;
  logic        addr_take;
  logic        cfg_take;
  logic        alt_take;
  logic        wake;
  logic        addr_phase;

  ////////////////////////////////////////////////////////////////////////
  // Event decode

  assign reset_done = bus_rst_q && !bus_reset_in;
  assign pwr_chg    = self_pwr_q ^ self_powered_in;
  // Reset signalling counts as activity so a suspended device wakes
  assign wake       = bus_activity_in || bus_reset_in;
  assign go_susp    = (state_q == UDS_ST_POWERED || is_live(state_q)) &&
                      (idle_w || (is_live(state_q) && !port_enabled_in));
  assign pwr_drop   = pwr_chg && state_q == UDS_ST_CONFIGURED &&
                      cfg_single_mode_in;
  assign pwr_fall   = pwr_chg && self_pwr_q && cfg_high_power_in &&
                      state_q == UDS_ST_CONFIGURED && !cfg_single_mode_in;
  assign base_ok    = attached_in && vbus_in && !reset_done &&
                      is_live(state_q) && !go_susp && !pwr_drop &&
                      !pwr_fall;
  assign addr_take  = base_ok && set_addr_in &&
                      (state_q == UDS_ST_DEFAULT ||
                       state_q == UDS_ST_ADDRESS);
  assign cfg_take   = base_ok && !set_addr_in && set_cfg_in &&
                      (state_q == UDS_ST_ADDRESS ||
                       state_q == UDS_ST_CONFIGURED);
  assign alt_take   = base_ok && set_alt_in &&
                      state_q == UDS_ST_CONFIGURED;

  uds_idle_timer #(
    .CYCLES (IDLE_CYCLES)
  ) u_idle (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .activity_in (wake),
    .idle_out    (idle_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // Device state

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_rst_q  <= 1'b0;
      self_pwr_q <= 1'b0;
    end else begin
      bus_rst_q  <= bus_reset_in;
      self_pwr_q <= self_powered_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q    <= UDS_ST_UNATT;
      resume_q   <= UDS_ST_POWERED;
      dev_addr_q <= `UDS_DEF_ADDR;
      cfg_q      <= `UDS_CFG_NONE;
    end else if (!attached_in) begin
      state_q    <= UDS_ST_UNATT;
      dev_addr_q <= `UDS_DEF_ADDR;
      cfg_q      <= `UDS_CFG_NONE;
    end else if (!vbus_in) begin
      state_q    <= UDS_ST_ATTACHED;
      dev_addr_q <= `UDS_DEF_ADDR;
      cfg_q      <= `UDS_CFG_NONE;
    end else if (reset_done) begin
      state_q    <= UDS_ST_DEFAULT;
      dev_addr_q <= `UDS_DEF_ADDR;
      cfg_q      <= `UDS_CFG_NONE;
    end else if (state_q == UDS_ST_UNATT ||
                 state_q == UDS_ST_ATTACHED) begin
      state_q <= UDS_ST_POWERED;
    end else if (state_q == UDS_ST_SUSPENDED) begin
      // Address and configuration untouched while asleep
      if (wake) begin
        state_q <= resume_q;
      end
    end else if (go_susp) begin
      state_q  <= UDS_ST_SUSPENDED;
      resume_q <= state_q;
    end else if (pwr_drop) begin
      state_q    <= UDS_ST_POWERED;
      dev_addr_q <= `UDS_DEF_ADDR;
      cfg_q      <= `UDS_CFG_NONE;
    end else if (pwr_fall) begin
      state_q <= UDS_ST_ADDRESS;
      cfg_q   <= `UDS_CFG_NONE;
    end else if (addr_take) begin
      dev_addr_q <= addr_val_in;
      state_q    <= (addr_val_in != `UDS_DEF_ADDR) ?
                    UDS_ST_ADDRESS : UDS_ST_DEFAULT;
    end else if (cfg_take) begin
      cfg_q   <= cfg_val_in;
      state_q <= (cfg_val_in != `UDS_CFG_NONE) ?
                 UDS_ST_CONFIGURED : UDS_ST_ADDRESS;
    end
  end

  // Speed fixed when reset ends; needs local permission bit
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hs_q <= 1'b0;
    end else if (!attached_in) begin
      hs_q <= 1'b0;
    end else if (reset_done) begin
      hs_q <= ctrl_q[`UDS_CTRL_HS_BIT] && hs_chirp_ok_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rwake_q <= 1'b0;
    end else if (reset_done || !attached_in) begin
      rwake_q <= 1'b0;
    end else if (rwake_set_in && ctrl_q[`UDS_CTRL_RWK_BIT] &&
                 is_live(state_q)) begin
      rwake_q <= 1'b1;
    end else if (rwake_clr_in) begin
      rwake_q <= 1'b0;
    end
  end

  // Address match; endpoint zero needs no configuration
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= tok_valid_in && !bus_reset_in && is_live(state_q) &&
                  tok_addr_in == dev_addr_q &&
                  (tok_ep_in == 4'h0 ||
                   state_q == UDS_ST_CONFIGURED);
    end
  end

  uds_ep_toggle u_tog (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .clr_all_in  (reset_done || cfg_take || !attached_in),
    .clr_mask_in (alt_take ? alt_ep_mask_in : '0),
    .flip_in     ((state_q == UDS_ST_CONFIGURED) ? ep_flip_in : '0),
    .toggle_out  (ep_toggle_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register slave, zero wait states

  always_comb begin
    status_w = '0;
    status_w[`UDS_STAT_ST_LSB +: 3]  = state_q;
    status_w[`UDS_STAT_SUS_BIT]      = state_q == UDS_ST_SUSPENDED;
    status_w[`UDS_STAT_SLF_BIT]      = self_pwr_q;
    status_w[`UDS_STAT_HS_BIT]       = hs_q;
    status_w[`UDS_STAT_RWK_BIT]      = rwake_q;
    status_w[`UDS_STAT_ADR_LSB +: 7] = dev_addr_q;
    status_w[`UDS_STAT_CFG_LSB +: 8] = cfg_q;
  end

  assign addr_phase = hsel_in && htrans_in[1] && hready_in;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend_q <= 1'b0;
      wr_sel_q  <= UDS_REG_NONE;
    end else if (hready_in) begin
      wr_pend_q <= addr_phase && hwrite_in;
      wr_sel_q  <= reg_sel(haddr_in);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= `UDS_CTRL_RST;
    end else if (wr_pend_q && wr_sel_q == UDS_REG_CTRL) begin
      ctrl_q <= hwdata_in[1:0];
    end
  end

  // Read data sampled at the address phase; unmapped reads give zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_phase && !hwrite_in) begin
      if (reg_sel(haddr_in) == UDS_REG_CTRL) begin
        hrdata_q <= {30'h0000_0000, ctrl_q};
      end else if (reg_sel(haddr_in) == UDS_REG_STAT) begin
        hrdata_q <= status_w;
      end else if (reg_sel(haddr_in) == UDS_REG_TOGL) begin
        hrdata_q <= {16'h0000, ep_toggle_out};
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hreadyout_out <= 1'b0;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign state_out      = state_q;
  assign dev_addr_out   = dev_addr_q;
  assign cfg_val_out    = cfg_q;
  assign suspended_out  = status_w[`UDS_STAT_SUS_BIT] && 1'b1;
  assign rwake_en_out   = rwake_q;
  assign self_pwr_out   = self_pwr_q;
  assign high_speed_out = hs_q;
  assign accept_out     = accept_q;
  assign hrdata_out     = hrdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_no_early_accept: assert property (
    !is_live(state_q) |=> !accept_q)
    else $error("token accepted before first bus reset");

  a_reset_default: assert property (
    attached_in && vbus_in && reset_done |=>
      state_q == UDS_ST_DEFAULT && dev_addr_q == `UDS_DEF_ADDR &&
      cfg_q == `UDS_CFG_NONE)
    else $error("bus reset did not give a clean Default state");

  a_reset_toggles: assert property (
    reset_done |=> ep_toggle_out == '0 && !rwake_q)
    else $error("bus reset left toggles or wakeup enable set");

  a_ep0_answer: assert property (
    tok_valid_in && !bus_reset_in && tok_ep_in == 4'h0 &&
    is_live(state_q) && tok_addr_in == dev_addr_q |=> accept_q)
    else $error("default pipe token not accepted");

  a_addr_move: assert property (
    addr_take && state_q == UDS_ST_DEFAULT &&
    addr_val_in != `UDS_DEF_ADDR |=>
      state_q == UDS_ST_ADDRESS && dev_addr_q == $past(addr_val_in))
    else $error("address assignment not applied");

  a_cfg_nonzero: assert property (
    state_q == UDS_ST_CONFIGURED |-> cfg_q != `UDS_CFG_NONE)
    else $error("configured with zero configuration value");

  a_cfg_data0: assert property (
    cfg_take |=> ep_toggle_out == '0)
    else $error("configure left a toggle at DATA1");

  a_susp_keep: assert property (
    state_q == UDS_ST_SUSPENDED && attached_in && vbus_in &&
    !reset_done |=> $stable(dev_addr_q) && $stable(cfg_q))
    else $error("suspend lost address or configuration");

  a_sel_suspend: assert property (
    is_live(state_q) && attached_in && vbus_in && !reset_done &&
    !port_enabled_in |=> state_q == UDS_ST_SUSPENDED)
    else $error("disabled port did not suspend the device");

  a_resume_prior: assert property (
    state_q == UDS_ST_SUSPENDED && attached_in && vbus_in &&
    !reset_done && bus_activity_in |=>
      state_q == $past(resume_q))
    else $error("resume did not restore the prior state");

  a_power_gate: assert property (
    !vbus_in |=> state_q == UDS_ST_UNATT ||
                 state_q == UDS_ST_ATTACHED)
    else $error("powered state without bus supply");

  a_high_pwr_fall: assert property (
    pwr_fall && attached_in && vbus_in && !reset_done && !go_susp |=>
      state_q == UDS_ST_ADDRESS ##1
      state_q == UDS_ST_ADDRESS || state_q == UDS_ST_SUSPENDED ||
      state_q == UDS_ST_DEFAULT || state_q == UDS_ST_CONFIGURED ||
      !attached_in || !vbus_in)
    else $error("bus power switch did not fall back to Address");

  a_speed_pick: assert property (
    reset_done && attached_in |=>
      hs_q == $past(ctrl_q[`UDS_CTRL_HS_BIT] && hs_chirp_ok_in))
    else $error("speed not decided at end of reset");

endmodule : uds_state_tracker

//--- dv/uds_host_model.sv
`timescale 1ns/1ps

module uds_host_model #(
  parameter int unsigned WAIT_CYC = 10
) (
  input  wire logic       clk_in,        // Device clock
  output logic            bus_reset_out, // Reset signalling
  output logic            activity_out,  // Bus traffic
  output logic            port_en_out,   // Hub port enabled
  output logic            tok_valid_out, // Token strobe
  output logic [6:0]      tok_addr_out,  // Token address
  output logic [3:0]      tok_ep_out     // Token endpoint
);
  initial begin
    bus_reset_out = 1'b0;
    activity_out  = 1'b1;
    port_en_out   = 1'b0;
    tok_valid_out = 1'b0;
    tok_addr_out  = 7'h00;
    tok_ep_out    = 4'h0;
  end

  //////////////////////////////////////////////////////////////////////
  // Settling time after attach, scaled down
  task automatic port_reset();
    activity_out <= 1'b1;
    repeat (WAIT_CYC) @(posedge clk_in);
    bus_reset_out <= 1'b1;
    port_en_out   <= 1'b1;
    repeat (4) @(posedge clk_in);
    bus_reset_out <= 1'b0;
    @(posedge clk_in);
  endtask : port_reset

  // Lines flip once released, so stale values never match
  task automatic token(input logic [6:0] a, input logic [3:0] e);
    @(posedge clk_in);
    tok_valid_out <= 1'b1;
    tok_addr_out  <= a;
    tok_ep_out    <= e;
    @(posedge clk_in);
    tok_valid_out <= 1'b0;
    tok_addr_out  <= ~a;
    tok_ep_out    <= ~e;
  endtask : token

  task automatic link(input logic act, input logic en, input int n);
    @(posedge clk_in);
    // A disabled hub port forwards no traffic downstream
    activity_out <= act && en;
    port_en_out  <= en;
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : link
endmodule : uds_host_model

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "uds_map.svh"

module testbench
  import uds_pkg::*;
;
  localparam int unsigned IDLE = 20;
  logic clk_in, rst_b_in, hsel_in, hwrite_in, attached_in, vbus_in;
  logic self_powered_in, hs_chirp_ok_in, cfg_single_mode_in;
  logic cfg_high_power_in, set_addr_in, set_cfg_in, set_alt_in;
  logic rwake_set_in, rwake_clr_in, hreadyout_out, hresp_out;
  logic suspended_out, rwake_en_out, self_pwr_out, high_speed_out;
  logic accept_out;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic [11:0] haddr_in;
  logic [31:0] hwdata_in, hrdata_out, rd;
  logic [6:0]  addr_val_in, dev_addr_out;
  logic [7:0]  cfg_val_in, cfg_val_out;
  logic [15:0] alt_ep_mask_in, ep_flip_in, ep_toggle_out;
  uds_state_t  state_out;
  wire logic   hready_in, bus_reset_in, bus_activity_in, tok_valid_in;
  wire logic   port_enabled_in;
  wire logic [6:0] tok_addr_in;
  wire logic [3:0] tok_ep_in;
  int n_fail = 0;
  int checks_done = 0;

  assign hready_in = hreadyout_out;

  uds_state_tracker #(.IDLE_CYCLES(IDLE)) DUT (
    .clk_in, .rst_b_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out,
    .hresp_out, .attached_in, .vbus_in, .self_powered_in, .bus_reset_in,
    .bus_activity_in, .port_enabled_in, .hs_chirp_ok_in, .tok_valid_in,
    .tok_addr_in, .tok_ep_in, .set_addr_in, .addr_val_in, .set_cfg_in,
    .cfg_val_in, .set_alt_in, .alt_ep_mask_in, .cfg_single_mode_in,
    .cfg_high_power_in, .rwake_set_in, .rwake_clr_in, .ep_flip_in,
    .state_out, .dev_addr_out, .cfg_val_out, .suspended_out,
    .rwake_en_out, .self_pwr_out, .high_speed_out, .accept_out,
    .ep_toggle_out);

  uds_host_model host (
    .clk_in, .bus_reset_out(bus_reset_in), .activity_out(bus_activity_in),
    .port_en_out(port_enabled_in), .tok_valid_out(tok_valid_in),
    .tok_addr_out(tok_addr_in), .tok_ep_out(tok_ep_in));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  // Codes 0..4 pulse one request line, 5 advances toggles
  task automatic ev(input int k, input logic [15:0] v);
    @(posedge clk_in);
    addr_val_in    <= v[6:0];
    cfg_val_in     <= v[7:0];
    alt_ep_mask_in <= v;
    ep_flip_in     <= (k == 5) ? v : 16'h0000;
    {rwake_clr_in, rwake_set_in, set_alt_in, set_cfg_in, set_addr_in}
      <= 5'(1 << k);
    @(posedge clk_in);
    {rwake_clr_in, rwake_set_in, set_alt_in, set_cfg_in, set_addr_in}
      <= 5'h0;
    ep_flip_in <= 16'h0000;
    settle(1);
  endtask : ev

  // Address then data phase, each held until ready is sampled high
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    hsel_in   <= 1'b1;
    htrans_in <= 2'b10;
    haddr_in  <= a;
    hwrite_in <= w;
    repeat (2) begin
      @(posedge clk_in);
      while (hready_in !== 1'b1) begin
        n++;
        if (n > 50) begin
          n_fail++;
          end_sim();
        end
        @(posedge clk_in);
      end
      htrans_in <= 2'b00;
      hwdata_in <= wd;
    end
    r = hrdata_out;
    hsel_in <= 1'b0;
  endtask : ahb

  task automatic tok(input logic [6:0] a, input logic e);
    host.token(a, 4'h0);
    @(negedge clk_in);
    chk("accept", accept_out, e);
  endtask : tok

  //////////////////////////////////////////////////////////////////////
  initial begin
    {hsel_in, hwrite_in, attached_in, vbus_in, self_powered_in} = '0;
    {cfg_single_mode_in, cfg_high_power_in, hwdata_in, haddr_in} = '0;
    {set_addr_in, set_cfg_in, set_alt_in, rwake_set_in, rwake_clr_in} = '0;
    {addr_val_in, cfg_val_in, alt_ep_mask_in, ep_flip_in} = '0;
    htrans_in = 2'b00;
    hsize_in = 3'b010;
    hs_chirp_ok_in = 1'b1;
    rst_b_in = 1'b0;
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    attached_in <= 1'b1;
    settle(3);
    chk("state", state_out, UDS_ST_ATTACHED);
    vbus_in <= 1'b1;
    settle(3);
    chk("state", state_out, UDS_ST_POWERED);
    tok(7'h00, 1'b0);
    ahb(1'b1, `UDS_CTRL_OFS, 32'h0000_0003, rd);
    host.port_reset();
    settle(2);
    chk("state", state_out, UDS_ST_DEFAULT);
    chk("addr", dev_addr_out, `UDS_DEF_ADDR);
    chk("speed", high_speed_out, 1'b1);
    tok(7'h00, 1'b1);
    ev(0, 16'h0005);
    chk("state", state_out, UDS_ST_ADDRESS);
    chk("addr", dev_addr_out, 7'h05);
    tok(7'h05, 1'b1);
    tok(7'h00, 1'b0);
    ev(1, 16'h0000);
    chk("state", state_out, UDS_ST_ADDRESS);
    ev(1, 16'h0001);
    chk("state", state_out, UDS_ST_CONFIGURED);
    ev(5, 16'h0006);
    ev(2, 16'h0002);
    chk("toggle", ep_toggle_out, 16'h0004);
    ev(1, 16'h0002);
    chk("toggle", ep_toggle_out, 16'h0000);
    ev(3, 16'h0000);
    chk("wake_en", rwake_en_out, 1'b1);
    ev(4, 16'h0000);
    chk("wake_en", rwake_en_out, 1'b0);
    ev(3, 16'h0000);
    chk("wake_en", rwake_en_out, 1'b1);
    ahb(1'b0, `UDS_STAT_OFS, 32'h0000_0000, rd);
    chk("status", rd, 32'h0002_0565);
    host.link(1'b0, 1'b1, IDLE + 6);
    chk("state", state_out, UDS_ST_SUSPENDED);
    chk("susp", suspended_out, 1'b1);
    chk("cfg", cfg_val_out, 8'h02);
    host.link(1'b1, 1'b1, 2);
    chk("state", state_out, UDS_ST_CONFIGURED);
    host.link(1'b1, 1'b0, 2);
    chk("state", state_out, UDS_ST_SUSPENDED);
    host.link(1'b1, 1'b1, 2);
    chk("addr", dev_addr_out, 7'h05);
    self_powered_in <= 1'b1;
    cfg_single_mode_in <= 1'b1;
    settle(2);
    chk("power", self_pwr_out, 1'b1);
    chk("state", state_out, UDS_ST_POWERED);
    chk("cfg", cfg_val_out, `UDS_CFG_NONE);
    host.link(1'b0, 1'b1, IDLE + 6);
    host.port_reset();
    settle(2);
    chk("state", state_out, UDS_ST_DEFAULT);
    chk("wake_en", rwake_en_out, 1'b0);
    cfg_single_mode_in <= 1'b0;
    cfg_high_power_in <= 1'b1;
    ev(0, 16'h0007);
    ev(1, 16'h0001);
    self_powered_in <= 1'b0;
    settle(2);
    chk("state", state_out, UDS_ST_ADDRESS);
    chk("addr", dev_addr_out, 7'h07);
    ahb(1'b0, 12'h0FC, 32'h0000_0000, rd);
    chk("unmapped", rd, 32'h0000_0000);
    chk("hresp", hresp_out, 1'b0);
    chk("susp", suspended_out, 1'b0);
    end_sim();
  end
endmodule : testbench
